// ### rtl/pwmg_cfg.svh
// register offsets, field positions, reset values and timing figures
// for the pulse-width output generator; definitions only
`ifndef PWMG_CFG_SVH
`define PWMG_CFG_SVH

// =====================================================================
// register map
`define PWMG_OFS_PW_HIGH 16'hFFBD
`define PWMG_OFS_PW_LOW 16'hFFBE
`define PWMG_OFS_RATE_CTRL 16'hFFBF

// =====================================================================
// fields and reset values
`define PWMG_EN_BIT 7
`define PWMG_RATE_MSB 6
`define PWMG_RST_BYTE 8'h00
`define PWMG_DUTY_FULL 16'hFFFF

// =====================================================================
// timing: each period spans 65536 phase units; the phase advances by
// rate_code + 1 on every step tick, so code 0 gives 732.4 Hz and code
// 127 gives 93.75 kHz with a 48 MHz step rate
`define PWMG_CLK_HZ 250000000
`define PWMG_STEP_HZ 48000000

`endif

// ### rtl/pwmg_pkg.sv
// shared types of the pulse-width output generator
// assumes nothing of its surroundings
package pwmg_pkg;

  typedef logic [7:0] pwmg_byte_t;
  typedef logic [15:0] pwmg_word_t;
  typedef logic [15:0] pwmg_addr_t;

endpackage

// ### rtl/pwmg_frac_tick.sv
// fractional clock divider: one-cycle tick at a mean rate of
// step_hz out of clk_hz
// assumes ref_clk is the only clock and step_hz is below clk_hz
`timescale 1ns/100ps

module pwmg_frac_tick #(
  parameter int unsigned CLK_HZ = 250000000,
  parameter int unsigned STEP_HZ = 48000000
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic run,
  output logic tick
);

  localparam logic [28:0] ACC_DEN = 29'(CLK_HZ);
  localparam logic [28:0] ACC_NUM = 29'(STEP_HZ);

  logic [28:0] acc;
  logic [28:0] next_acc;

  // error accumulator keeps the long-run rate exact without a pll
  always_comb
  begin
    next_acc = acc + ACC_NUM;
    tick = run && (next_acc >= ACC_DEN);
    if (next_acc >= ACC_DEN)
    begin
      next_acc = next_acc - ACC_DEN;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc <= 29'h0000000;
    end
    else if (clk_en)
    begin
      acc <= run ? next_acc : 29'h0000000;
    end
  end

endmodule // pwmg_frac_tick

// ### rtl/pwmg_top.sv
// single-channel pulse-width output generator with three byte registers
// on the controller's memory-mapped data bus
// assumes a synchronous bus: address and strobes valid at the ref_clk edge
`timescale 1ns/100ps
`include "pwmg_cfg.svh"

module pwmg_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire pwmg_pkg::pwmg_addr_t mem_addr,
  input wire logic mem_wr_stb,
  input wire logic mem_rd_stb,
  input wire pwmg_pkg::pwmg_byte_t mem_wdata,
  output pwmg_pkg::pwmg_byte_t mem_rdata,
  output logic mem_hit,
  output logic pwm_active,
  output logic pwm_out
);

  // ===================================================================
  // registers
  pwmg_pkg::pwmg_byte_t pulse_width_high_byte;
  pwmg_pkg::pwmg_byte_t pulse_width_low_byte;
  pwmg_pkg::pwmg_byte_t rate_and_enable_control;

  logic sel_high;
  logic sel_low;
  logic sel_ctrl;

  assign sel_high = (mem_addr == `PWMG_OFS_PW_HIGH);
  assign sel_low = (mem_addr == `PWMG_OFS_PW_LOW);
  assign sel_ctrl = (mem_addr == `PWMG_OFS_RATE_CTRL);
  assign mem_hit = sel_high || sel_low || sel_ctrl;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_width_high_byte <= `PWMG_RST_BYTE;
    end
    else if (clk_en && mem_wr_stb && sel_high)
    begin
      pulse_width_high_byte <= mem_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulse_width_low_byte <= `PWMG_RST_BYTE;
    end
    else if (clk_en && mem_wr_stb && sel_low)
    begin
      pulse_width_low_byte <= mem_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rate_and_enable_control <= `PWMG_RST_BYTE;
    end
    else if (clk_en && mem_wr_stb && sel_ctrl)
    begin
      rate_and_enable_control <= mem_wdata;
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_rdata <= `PWMG_RST_BYTE;
    end
    else if (clk_en && mem_rd_stb)
    begin
      mem_rdata <= sel_high ? pulse_width_high_byte :
                   sel_low ? pulse_width_low_byte :
                   sel_ctrl ? rate_and_enable_control : 8'h00;
    end
  end

  // ===================================================================
  // settings in use for the current period
  logic modulator_output_enable;
  logic [6:0] rate_code;
  pwmg_pkg::pwmg_word_t duty_live;
  pwmg_pkg::pwmg_word_t duty_cur;
  logic [7:0] step_cur;
  logic run;
  logic tick;
  logic boundary;
  pwmg_pkg::pwmg_word_t phase;
  logic [16:0] phase_sum;

  assign modulator_output_enable = rate_and_enable_control[`PWMG_EN_BIT];
  assign rate_code = rate_and_enable_control[`PWMG_RATE_MSB:0];
  assign duty_live = {pulse_width_high_byte, pulse_width_low_byte};
  assign phase_sum = {1'b0, phase} + {9'h000, step_cur};
  assign boundary = tick && phase_sum[16];

  // enable is not deferred: turning off must silence the pin at once
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run <= 1'b0;
    end
    else if (clk_en)
    begin
      run <= modulator_output_enable;
    end
  end

  // while idle the shadows track the registers so the first period is fresh
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      duty_cur <= 16'h0000;
      step_cur <= 8'h01;
    end
    else if (clk_en && (!run || boundary))
    begin
      duty_cur <= duty_live;
      step_cur <= {1'b0, rate_code} + 8'h01;
    end
  end

  pwmg_frac_tick #(
    .CLK_HZ(`PWMG_CLK_HZ),
    .STEP_HZ(`PWMG_STEP_HZ)
  ) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(run),
    .tick(tick)
  );

  // phase wraps modulo 65536; a carry out marks the period boundary
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        phase <= 16'h0000;
      end
      else if (tick)
      begin
        phase <= phase_sum[15:0];
      end
    end
  end

  // ===================================================================
  // output pin
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        pwm_out <= 1'b0;
      end
      else if (duty_cur == `PWMG_DUTY_FULL)
      begin
        pwm_out <= 1'b1;
      end
      else
      begin
        pwm_out <= (phase < duty_cur);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_active <= 1'b0;
    end
    else if (clk_en)
    begin
      pwm_active <= run;
    end
  end

  // ===================================================================
  // assertions
  sequence s_wr_low;
    clk_en && mem_wr_stb && sel_low;
  endsequence

  sequence s_wr_high;
    clk_en && mem_wr_stb && sel_high;
  endsequence

  property p_disabled_low;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && !modulator_output_enable) ##1 (clk_en && !run) |=> !pwm_out;
  endproperty
  a_disabled_low: assert property (p_disabled_low)
    else $error("output high while disabled");

  property p_step_from_code;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && tick) |=> (phase == 16'($past(phase) + {8'h00, $past(step_cur)}));
  endproperty
  a_step_from_code: assert property (p_step_from_code)
    else $error("phase did not advance by rate step");

  // the bus master leaves one idle edge between a write and the next read
  sequence s_idle_gap;
    clk_en && !mem_wr_stb;
  endsequence

  sequence s_rd_low;
    clk_en && mem_rd_stb && sel_low && !mem_wr_stb;
  endsequence

  property p_low_readback;
    @(posedge ref_clk) disable iff (!reset_n)
    s_wr_low ##1 s_idle_gap ##1 s_rd_low
      |=> (mem_rdata == $past(mem_wdata, 3));
  endproperty
  a_low_readback: assert property (p_low_readback)
    else $error("low width byte read back wrong");

  property p_high_store;
    @(posedge ref_clk) disable iff (!reset_n)
    s_wr_high |=> (duty_live[15:8] == $past(mem_wdata));
  endproperty
  a_high_store: assert property (p_high_store)
    else $error("high width byte not stored");

  property p_zero_low;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && duty_cur == 16'h0000) |=> !pwm_out;
  endproperty
  a_zero_low: assert property (p_zero_low)
    else $error("zero duty drove output high");

  property p_full_high;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && duty_cur == `PWMG_DUTY_FULL) |=> pwm_out;
  endproperty
  a_full_high: assert property (p_full_high)
    else $error("full duty drove output low");

  property p_latch_at_boundary;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && boundary) |=> (duty_cur == $past(duty_live));
  endproperty
  a_latch_at_boundary: assert property (p_latch_at_boundary)
    else $error("duty not taken at period boundary");

  property p_hold_midperiod;
    @(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && !boundary && $past(run)) |=> $stable(duty_cur);
  endproperty
  a_hold_midperiod: assert property (p_hold_midperiod)
    else $error("duty changed inside a period");

endmodule // pwmg_top

// ### tb/pwmg_tb.sv
// self-checking bench for the pulse-width output generator
// assumes pwmg_top, pwmg_pkg and pwmg_cfg.svh are compiled alongside
`timescale 1ns/100ps
`include "pwmg_cfg.svh"

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module testbench;
  logic ref_clk;
  logic reset_n;
  logic clk_en;
  logic mem_wr_stb;
  logic mem_rd_stb;
  logic mem_hit;
  logic pwm_active;
  logic pwm_out;
  pwmg_pkg::pwmg_addr_t mem_addr;
  pwmg_pkg::pwmg_byte_t mem_wdata;
  pwmg_pkg::pwmg_byte_t mem_rdata;
  int err_count;
  int n_compared;
  int hi;
  int rises;

  pwmg_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .mem_addr(mem_addr), .mem_wr_stb(mem_wr_stb), .mem_rd_stb(mem_rd_stb),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
    .pwm_active(pwm_active), .pwm_out(pwm_out));

  // =====================================================================
  // clock and bus tasks
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wr(input pwmg_pkg::pwmg_addr_t a, input pwmg_pkg::pwmg_byte_t d);
    @(posedge ref_clk);
    #1 mem_addr = a;
    mem_wdata = d;
    mem_wr_stb = 1'b1;
    @(posedge ref_clk);
    #1 mem_wr_stb = 1'b0;
  endtask

  task automatic rd_chk(input pwmg_pkg::pwmg_addr_t a, input pwmg_pkg::pwmg_byte_t e);
    @(posedge ref_clk);
    #1 mem_addr = a;
    mem_rd_stb = 1'b1;
    @(posedge ref_clk);
    #1 mem_rd_stb = 1'b0;
    `CHK(mem_rdata, e)
  endtask

  // counts high cycles and rising edges of the output over n cycles
  task automatic measure(input int n);
    logic prev;
    hi = 0;
    rises = 0;
    prev = pwm_out;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      if (pwm_out === 1'b1) hi++;
      if (pwm_out === 1'b1 && prev === 1'b0) rises++;
      prev = pwm_out;
    end
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset_and_map();
    rd_chk(`PWMG_OFS_PW_HIGH, 8'h00);
    rd_chk(`PWMG_OFS_PW_LOW, 8'h00);
    `CHK(mem_hit, 1'b1)
    rd_chk(`PWMG_OFS_RATE_CTRL, 8'h00);
    `CHK(pwm_active, 1'b0)
    wr(16'hFFC0, 8'hA5);
    rd_chk(16'hFFC0, 8'h00);
    `CHK(mem_hit, 1'b0)
  endtask

  task automatic t_readback();
    wr(`PWMG_OFS_PW_LOW, 8'h5A);
    rd_chk(`PWMG_OFS_PW_LOW, 8'h5A);
    wr(`PWMG_OFS_PW_HIGH, 8'hC3);
    rd_chk(`PWMG_OFS_PW_HIGH, 8'hC3);
    rd_chk(`PWMG_OFS_PW_LOW, 8'h5A);
    wr(`PWMG_OFS_RATE_CTRL, 8'h7F);
    rd_chk(`PWMG_OFS_RATE_CTRL, 8'h7F);
    `CHK(pwm_active, 1'b0)
    // a write while the clock enable is low must be lost
    clk_en = 1'b0;
    wr(`PWMG_OFS_PW_LOW, 8'h11);
    clk_en = 1'b1;
    rd_chk(`PWMG_OFS_PW_LOW, 8'h5A);
  endtask

  task automatic t_extremes();
    wr(`PWMG_OFS_PW_HIGH, 8'hFF);
    wr(`PWMG_OFS_PW_LOW, 8'hFF);
    wr(`PWMG_OFS_RATE_CTRL, 8'hFF);
    repeat (3) @(posedge ref_clk);
    #1 `CHK(pwm_active, 1'b1)
    measure(6000);
    `CHK(hi, 6000)
    wr(`PWMG_OFS_RATE_CTRL, 8'h7F);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(pwm_out, 1'b0)
    `CHK(pwm_active, 1'b0)
    wr(`PWMG_OFS_PW_HIGH, 8'h00);
    wr(`PWMG_OFS_PW_LOW, 8'h00);
    wr(`PWMG_OFS_RATE_CTRL, 8'hFF);
    measure(6000);
    `CHK(hi, 0)
    `CHK(pwm_out, 1'b0)
    `CHK(pwm_active, 1'b1)
  endtask

  // code 127: 512 ticks at 48 MHz, about 2667 cycles a period
  task automatic t_duty_and_rate();
    wr(`PWMG_OFS_RATE_CTRL, 8'h00);
    wr(`PWMG_OFS_PW_HIGH, 8'h40);
    wr(`PWMG_OFS_RATE_CTRL, 8'hFF);
    measure(21333);
    `CHK(hi > 5270 && hi < 5400, 1'b1)
    `CHK(rises >= 7 && rises <= 9, 1'b1)
    // new width only lands at the next wrap; skip one period first
    wr(`PWMG_OFS_PW_HIGH, 8'hC0);
    repeat (2700) @(posedge ref_clk);
    measure(21333);
    `CHK(hi > 15930 && hi < 16070, 1'b1)
    `CHK(rises >= 7 && rises <= 9, 1'b1)
  endtask

  // =====================================================================
  // sequence, watchdog and verdict
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    err_count = 0;
    n_compared = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
    mem_wr_stb = 1'b0;
    mem_rd_stb = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    t_reset_and_map();
    t_readback();
    t_extremes();
    t_duty_and_rate();
    report_and_stop();
  end

  // the tests need roughly 57000 cycles
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule // testbench
